/* rtl/flash_host_pkg.sv */
package flash_host_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam logic [10:0] UNLOCK1_ADDR = 11'h555;
  localparam logic [10:0] UNLOCK2_ADDR = 11'h2AA;
  localparam logic [7:0] UNLOCK1_DATA = 8'hAA;
  localparam logic [7:0] UNLOCK2_DATA = 8'h55;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_BYPASS = 8'h20;
  localparam logic [7:0] CMD_BYPASS_EXIT1 = 8'h90;
  localparam logic [7:0] CMD_BYPASS_EXIT2 = 8'h00;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam int POLL_BIT = 7;
  localparam int ERR_BIT = 5;
  localparam int TIMER_BIT = 3;
  localparam int CLK_NS = 100;
  // strobe phases: setup and low one cycle each, high at least two cycles, at 100 ns
  localparam int SEC_WINDOW_US = 50;
  localparam int SEC_WINDOW_CYC = (SEC_WINDOW_US * 1000) / CLK_NS;
  // suspend takes effect within 20 us, wait that long then finish without a status poll
  localparam int SUSPEND_US = 20;
  localparam int SUSPEND_CYC = (SUSPEND_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] OP_PROGRAM = 3'h0;
  localparam logic [2:0] OP_CHIP_ERASE = 3'h1;
  localparam logic [2:0] OP_SECTOR_ERASE = 3'h2;
  localparam logic [2:0] OP_BYPASS_ENTER = 3'h3;
  localparam logic [2:0] OP_BYPASS_EXIT = 3'h4;
  localparam logic [2:0] OP_SUSPEND = 3'h5;
  localparam logic [2:0] OP_RESUME = 3'h6;
  localparam logic [2:0] OP_RESET = 3'h7;
  localparam logic [2:0] SEQ_MAX = 3'h6;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
endpackage : flash_host_pkg

/* rtl/flash_seq_rom.sv */
`timescale 1ns/100ps
module flash_seq_rom
  import flash_host_pkg::*;
(
  input wire logic clock_i, // clock
  input wire logic ce_i, // clock enable
  input wire logic [2:0] op_i, // operation
  input wire logic [2:0] idx_i, // cycle index
  input wire logic bypass_i, // bypass mode active
  input wire logic [flash_host_pkg::ADDR_W-1:0] addr_i, // target address
  input wire logic [7:0] data_i, // program byte
  output logic [flash_host_pkg::ADDR_W-1:0] addr_o, // registered cycle address
  output logic [7:0] data_o, // registered cycle data
  output logic [2:0] len_o // cycles in sequence
);
  logic [ADDR_W-1:0] nxt_addr;
  logic [7:0] nxt_data;
  logic [2:0] nxt_len;
  logic [ADDR_W-1:0] u1;
  logic [ADDR_W-1:0] u2;
  assign u1 = {{(ADDR_W-11){1'b0}}, UNLOCK1_ADDR};
  assign u2 = {{(ADDR_W-11){1'b0}}, UNLOCK2_ADDR};

  always_comb begin
    nxt_addr = u1;
    nxt_data = UNLOCK1_DATA;
    nxt_len = 3'h1;
    if (idx_i == 3'h1) begin
      nxt_addr = u2;
      nxt_data = UNLOCK2_DATA;
    end else if (idx_i == 3'h4) begin
      nxt_addr = u2;
      nxt_data = UNLOCK2_DATA;
    end
    case (op_i)
      OP_PROGRAM: begin
        if (bypass_i) begin
          nxt_len = 3'h2;
          if (idx_i == 3'h0) nxt_data = CMD_PROGRAM;
          else begin
            nxt_addr = addr_i;
            nxt_data = data_i;
          end
        end else begin
          nxt_len = 3'h4;
          if (idx_i == 3'h2) nxt_data = CMD_PROGRAM;
          if (idx_i == 3'h3) begin
            nxt_addr = addr_i;
            nxt_data = data_i;
          end
        end
      end
      OP_CHIP_ERASE, OP_SECTOR_ERASE: begin
        nxt_len = SEQ_MAX;
        if (idx_i == 3'h2) nxt_data = CMD_ERASE_SETUP;
        if (idx_i == 3'h5) begin
          if (op_i == OP_CHIP_ERASE) nxt_data = CMD_CHIP_ERASE;
          else begin
            nxt_addr = addr_i;
            nxt_data = CMD_SECTOR_ERASE;
          end
        end
      end
      OP_BYPASS_ENTER: begin
        nxt_len = 3'h3;
        if (idx_i == 3'h2) nxt_data = CMD_BYPASS;
      end
      OP_BYPASS_EXIT: begin
        nxt_len = 3'h2;
        nxt_data = (idx_i == 3'h0) ? CMD_BYPASS_EXIT1 : CMD_BYPASS_EXIT2;
      end
      OP_SUSPEND: nxt_data = CMD_SUSPEND;
      OP_RESUME: nxt_data = CMD_RESUME;
      default: nxt_data = CMD_RESET;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (ce_i) begin
      addr_o <= nxt_addr;
      data_o <= nxt_data;
      len_o <= nxt_len;
    end
  end
endmodule : flash_seq_rom

/* rtl/flash_host_ctrl.sv */
`timescale 1ns/100ps
module flash_host_ctrl
  import flash_host_pkg::*;
(
  input wire logic clock_i, // 10 MHz clock
  input wire logic rst_b_i, // sync reset, active low
  input wire logic ce_i, // clock enable
  input wire logic req_i, // start an operation (level, taken when idle)
  input wire logic [2:0] op_i, // operation code
  input wire logic [flash_host_pkg::ADDR_W-1:0] addr_i, // target or sector address
  input wire logic [7:0] data_i, // program byte value
  input wire logic [7:0] dq_i, // flash data bus in
  output logic [flash_host_pkg::ADDR_W-1:0] flash_addr_o, // flash address
  output logic [7:0] dq_o, // flash data bus out
  output logic dq_oe_b_o, // low while host drives dq
  output logic chip_sel_b_o, // chip select, active low
  output logic write_en_b_o, // write strobe, active low
  output logic out_en_b_o, // output enable, active low
  output logic busy_o, // operation in progress
  output logic done_o, // one-cycle completion pulse
  output logic error_o, // one-cycle pulse with done on failure
  output logic bypass_o, // bypass mode active
  output logic window_open_o // sector window still open
);
  import flash_host_pkg::*;

  typedef enum {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_NEXT, ST_RD_SET, ST_RD_LOW, ST_RD_EVAL,
                ST_WAIT, ST_FINISH} state_e;

  state_e state_ff, nxt_state;
  logic [2:0] op_ff, nxt_op;
  logic [2:0] idx_ff, nxt_idx;
  logic [ADDR_W-1:0] tgt_ff, nxt_tgt;
  logic [7:0] byte_ff, nxt_byte;
  logic [15:0] cnt_ff, nxt_cnt;
  logic bypass_ff, nxt_bypass;
  logic window_ff, nxt_window;
  logic susp_ff, nxt_susp;
  logic err_ff, nxt_err;
  logic [ADDR_W-1:0] nxt_faddr;
  logic [7:0] nxt_dq;
  logic nxt_dq_oe_b, nxt_cs_b, nxt_we_b, nxt_oe_b, nxt_busy, nxt_done;
  logic [ADDR_W-1:0] rom_addr;
  logic [7:0] rom_data;
  logic [2:0] rom_len;
  logic legal;
  logic is_erase;

  flash_seq_rom u_rom (
    .clock_i(clock_i),
    .ce_i(ce_i),
    .op_i(op_ff),
    .idx_i(idx_ff),
    .bypass_i(bypass_ff),
    .addr_i(tgt_ff),
    .data_i(byte_ff),
    .addr_o(rom_addr),
    .data_o(rom_data),
    .len_o(rom_len)
  );

  // refuse what the device would ignore or treat as an error
  always_comb begin
    legal = 1'b1;
    if (bypass_ff) legal = (op_i == OP_PROGRAM) || (op_i == OP_BYPASS_EXIT);
    else if (op_i == OP_BYPASS_EXIT) legal = 1'b0;
    else if (op_i == OP_SUSPEND) legal = window_ff && !susp_ff;
    else if (op_i == OP_RESUME) legal = susp_ff;
    else if (susp_ff) legal = (op_i == OP_PROGRAM) || (op_i == OP_RESET);
    else if (window_ff) legal = (op_i == OP_SECTOR_ERASE) || (op_i == OP_RESET);
  end

  assign is_erase = (op_ff == OP_CHIP_ERASE) || (op_ff == OP_SECTOR_ERASE) || (op_ff == OP_RESUME);

  always_comb begin
    nxt_state = state_ff;
    nxt_op = op_ff;
    nxt_idx = idx_ff;
    nxt_tgt = tgt_ff;
    nxt_byte = byte_ff;
    nxt_cnt = cnt_ff;
    nxt_bypass = bypass_ff;
    nxt_window = window_ff;
    nxt_susp = susp_ff;
    nxt_err = err_ff;
    nxt_faddr = flash_addr_o;
    nxt_dq = dq_o;
    nxt_dq_oe_b = dq_oe_b_o;
    nxt_cs_b = 1'b1;
    nxt_we_b = 1'b1;
    nxt_oe_b = 1'b1;
    nxt_busy = busy_o;
    nxt_done = 1'b0;
    // window timer runs while idle too, so extra sectors can join
    if (window_ff && state_ff != ST_WAIT) begin
      if (cnt_ff == CNT_ZERO) nxt_window = 1'b0;
      else nxt_cnt = cnt_ff - 16'h0001;
    end
    case (state_ff)
      ST_IDLE: begin
        nxt_busy = 1'b0;
        if (req_i) begin
          nxt_op = op_i;
          nxt_tgt = addr_i;
          nxt_byte = data_i;
          nxt_idx = 3'h0;
          nxt_err = !legal;
          nxt_busy = 1'b1;
          // rom output lags op and index by one cycle, so let it catch up in next
          nxt_state = legal ? ST_NEXT : ST_FINISH;
        end
      end
      ST_SETUP: begin
        nxt_faddr = rom_addr;
        nxt_dq = rom_data;
        nxt_dq_oe_b = 1'b0;
        nxt_cs_b = 1'b0;
        nxt_state = ST_STROBE;
      end
      ST_STROBE: begin
        nxt_cs_b = 1'b0;
        nxt_we_b = 1'b0;
        nxt_state = ST_HOLD;
      end
      ST_HOLD: begin
        nxt_dq_oe_b = 1'b1;
        nxt_idx = idx_ff + 3'h1;
        nxt_state = ST_NEXT;
      end
      ST_NEXT: begin
        if (idx_ff < rom_len) nxt_state = ST_SETUP;
        else begin
          nxt_faddr = tgt_ff;
          nxt_state = ST_FINISH;
          case (op_ff)
            OP_BYPASS_ENTER: nxt_bypass = 1'b1;
            OP_BYPASS_EXIT: nxt_bypass = 1'b0;
            OP_RESET: nxt_window = 1'b0;
            OP_SUSPEND: begin
              nxt_susp = 1'b1;
              nxt_window = 1'b0;
              nxt_cnt = 16'(SUSPEND_CYC);
              nxt_state = ST_WAIT;
            end
            OP_SECTOR_ERASE: begin
              nxt_window = 1'b1;
              nxt_cnt = 16'(SEC_WINDOW_CYC);
            end
            OP_CHIP_ERASE, OP_PROGRAM: nxt_state = ST_RD_SET;
            OP_RESUME: nxt_susp = 1'b0;
            default: nxt_state = ST_FINISH;
          endcase
        end
      end
      ST_WAIT: begin
        if (cnt_ff == CNT_ZERO) nxt_state = ST_FINISH;
        else nxt_cnt = cnt_ff - 16'h0001;
      end
      ST_RD_SET: begin
        nxt_cs_b = 1'b0;
        nxt_oe_b = 1'b0;
        nxt_state = ST_RD_LOW;
      end
      ST_RD_LOW: begin
        nxt_cs_b = 1'b0;
        nxt_oe_b = 1'b0;
        nxt_state = ST_RD_EVAL;
      end
      ST_RD_EVAL: begin
        if (is_erase ? dq_i[POLL_BIT] : (dq_i[POLL_BIT] == byte_ff[POLL_BIT])) nxt_state = ST_FINISH;
        else if (dq_i[ERR_BIT]) begin
          nxt_err = 1'b1;
          nxt_op = OP_RESET;
          nxt_idx = 3'h0;
          nxt_state = ST_NEXT;
        end else nxt_state = ST_RD_SET;
      end
      default: begin // ST_FINISH
        nxt_done = 1'b1;
        nxt_busy = 1'b0;
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      state_ff <= ST_IDLE;
      op_ff <= OP_RESET;
      idx_ff <= 3'h0;
      tgt_ff <= '0;
      byte_ff <= 8'h00;
      cnt_ff <= CNT_ZERO;
      bypass_ff <= 1'b0;
      window_ff <= 1'b0;
      susp_ff <= 1'b0;
      err_ff <= 1'b0;
      flash_addr_o <= '0;
      dq_o <= 8'h00;
      dq_oe_b_o <= 1'b1;
      chip_sel_b_o <= 1'b1;
      write_en_b_o <= 1'b1;
      out_en_b_o <= 1'b1;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      error_o <= 1'b0;
      bypass_o <= 1'b0;
      window_open_o <= 1'b0;
    end else if (ce_i) begin
      state_ff <= nxt_state;
      op_ff <= nxt_op;
      idx_ff <= nxt_idx;
      tgt_ff <= nxt_tgt;
      byte_ff <= nxt_byte;
      cnt_ff <= nxt_cnt;
      bypass_ff <= nxt_bypass;
      window_ff <= nxt_window;
      susp_ff <= nxt_susp;
      err_ff <= nxt_err;
      flash_addr_o <= nxt_faddr;
      dq_o <= nxt_dq;
      dq_oe_b_o <= nxt_dq_oe_b;
      chip_sel_b_o <= nxt_cs_b;
      write_en_b_o <= nxt_we_b;
      out_en_b_o <= nxt_oe_b;
      busy_o <= nxt_busy;
      done_o <= nxt_done;
      error_o <= nxt_done & err_ff;
      bypass_o <= nxt_bypass;
      window_open_o <= nxt_window;
    end
  end
endmodule : flash_host_ctrl

/* verification/flash_host_chk.sv */
`timescale 1ns/100ps
module flash_host_chk (
  input wire logic clock_i, // clock
  input wire logic rst_b_i, // reset
  input wire logic req_i, // request
  input wire logic [flash_host_pkg::ADDR_W-1:0] flash_addr_o, // address
  input wire logic [7:0] dq_o, // data out
  input wire logic dq_oe_b_o, // drive enable
  input wire logic chip_sel_b_o, // select
  input wire logic write_en_b_o, // strobe
  input wire logic out_en_b_o, // read enable
  input wire logic busy_o, // busy
  input wire logic done_o, // done
  input wire logic error_o // error
);
  import flash_host_pkg::*;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_setup; !chip_sel_b_o && write_en_b_o && out_en_b_o; endsequence
  sequence s_strobe; !chip_sel_b_o && !write_en_b_o ##1 chip_sel_b_o && write_en_b_o; endsequence
  AST_WRITE_WALK: assert property ($fell(chip_sel_b_o) && out_en_b_o |-> s_setup ##1 s_strobe)
    else $error("write cycle out of shape");
  AST_STABLE_STROBE: assert property (!write_en_b_o |-> $stable(flash_addr_o) && $stable(dq_o) && !dq_oe_b_o)
    else $error("address or data moved under strobe");
  AST_POLL_READ: assert property ($fell(out_en_b_o) |-> !chip_sel_b_o && dq_oe_b_o ##1 !out_en_b_o)
    else $error("status read too short");
  AST_DONE_PULSE: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  AST_ERR_DONE: assert property (error_o |-> done_o)
    else $error("error without done");
  AST_TAKE: assert property ($rose(busy_o) |-> $past(req_i))
    else $error("busy without request");
  AST_IDLE_PINS: assert property (!busy_o && !done_o |-> chip_sel_b_o && write_en_b_o && out_en_b_o)
    else $error("pins move while idle");
  AST_RESET: assert property (disable iff (1'b0) !rst_b_i |=> chip_sel_b_o && write_en_b_o && dq_oe_b_o && !busy_o)
    else $error("reset state wrong");
endmodule : flash_host_chk

/* verification/flash_dev_model.sv */
`timescale 1ns/100ps
module flash_dev_model (
  input wire logic clock_i, // clock
  input wire logic [flash_host_pkg::ADDR_W-1:0] addr_i, // address
  input wire logic [7:0] dq_i, // host data
  input wire logic cs_b_i, // chip select
  input wire logic we_b_i, // write strobe
  input wire logic oe_b_i, // output enable
  output logic [7:0] dq_o // data to host
);
  import flash_host_pkg::*;
  logic [7:0] mem [0:255];
  logic [7:0] pd = 8'h00, last = 8'h00, wd, rd;
  logic [ADDR_W-1:0] wa;
  logic we_q = 1'b1, prg = 1'b0, byp = 1'b0, sus = 1'b0, err = 1'b0;
  int st = 0, busy = 0, kind = 0;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'hFF;
  always @* begin
    if (busy > 0 && kind == 1) rd = {~pd[7], busy[0], err, 5'h00};
    else if (busy > 0) rd = {1'b0, busy[0], 2'h0, busy <= 200, busy[0], 2'h0};
    else if (sus) rd = 8'h80;
    else rd = mem[addr_i[7:0]];
  end
  // a released bus shows the inverse of its last value, not a stale copy
  assign dq_o = (!cs_b_i && !oe_b_i) ? rd : ~last;
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    if (busy > 0) begin
      if (err && d == CMD_RESET) {err, busy} = '0;
      else if (kind == 2 && d == CMD_SUSPEND) {sus, busy} = {1'b1, 32'h0000_0000};
      else if (kind == 2 && busy > 200 && d != CMD_SECTOR_ERASE) busy = 0;
      return;
    end
    if (sus && d == CMD_RESUME) {sus, busy} = {1'b0, 32'h0000_02BC};
    else if (prg) begin
      err = |(d & ~mem[a[7:0]]);
      mem[a[7:0]] = mem[a[7:0]] & d;
      {prg, pd, kind, busy} = {1'b0, d, 32'h0000_0001, 32'h0000_0014};
    end else if (byp) begin
      if (st == 9) {byp, st} = {d != CMD_BYPASS_EXIT2, 32'h0000_0000};
      else if (d == CMD_PROGRAM) prg = 1'b1;
      else if (d == CMD_BYPASS_EXIT1) st = 9;
    end else if (d == CMD_RESET) st = 0;
    else if (st == 0 || st == 3) st = (a[10:0] == UNLOCK1_ADDR && d == UNLOCK1_DATA) ? st + 1 : 0;
    else if (st == 1 || st == 4) st = (a[10:0] == UNLOCK2_ADDR && d == UNLOCK2_DATA) ? st + 1 : 0;
    else begin
      prg = st == 2 && d == CMD_PROGRAM;
      byp = st == 2 && d == CMD_BYPASS;
      if (st == 5 && d == CMD_CHIP_ERASE) {kind, busy} = {32'h0000_0003, 32'h0000_0028};
      if (st == 5 && d == CMD_SECTOR_ERASE) {kind, busy} = {32'h0000_0002, 32'h0000_02BC};
      st = (st == 2 && d == CMD_ERASE_SETUP) ? 3 : 0;
    end
  endtask : wr
  always @(posedge clock_i) begin
    if (!cs_b_i && !oe_b_i) last = dq_o;
    if (we_b_i && !we_q) wr(wa, wd);
    if (!we_b_i && !cs_b_i) {wa, wd} = {addr_i, dq_i};
    we_q = we_b_i | cs_b_i;
    if (busy > 0 && !err) begin
      busy = busy - 1;
      if (busy == 0 && kind == 3) for (int i = 0; i < 256; i++) mem[i] = 8'hFF;
    end
  end
endmodule : flash_dev_model

/* verification/flash_host_ctrl_tb.sv */
`timescale 1ns/100ps
module flash_host_ctrl_tb;
  import flash_host_pkg::*;
  logic clock_i = 1'b0, rst_b_i = 1'b0, req_i = 1'b0;
  logic [2:0] op_i = 3'h0;
  logic [ADDR_W-1:0] addr_i = '0, fa;
  logic [7:0] data_i = 8'h00, dq_in, dq_out;
  logic oe_b, cs_b, we_b, re_b, busy, done, err, byp, win;
  int mismatches = 0, n_checks = 0, nwr = 0, n;
  always #50 clock_i = ~clock_i;
  always @(posedge we_b) nwr++;
  flash_host_ctrl u_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .ce_i(1'b1), .req_i(req_i), .op_i(op_i),
    .addr_i(addr_i), .data_i(data_i), .dq_i(dq_in), .flash_addr_o(fa), .dq_o(dq_out), .dq_oe_b_o(oe_b),
    .chip_sel_b_o(cs_b), .write_en_b_o(we_b), .out_en_b_o(re_b), .busy_o(busy), .done_o(done),
    .error_o(err), .bypass_o(byp), .window_open_o(win));
  flash_dev_model u_dev (.clock_i(clock_i), .addr_i(fa), .dq_i(dq_out), .cs_b_i(cs_b), .we_b_i(we_b),
    .oe_b_i(re_b), .dq_o(dq_in));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic complete_run;
    if (mismatches == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  // w: strobes expected on the pins, e: expected error flag
  task automatic run(input logic [2:0] op, input logic [ADDR_W-1:0] a, input logic [7:0] d, input int w,
    input logic e);
    @(posedge clock_i);
    nwr = 0;
    {op_i, addr_i, data_i, req_i} <= {op, a, d, 1'b1};
    @(posedge clock_i);
    req_i <= 1'b0;
    n = 0;
    do begin @(posedge clock_i); n++; end while (done !== 1'b1 && n < 3000);
    chk({7'h00, done}, 8'h01);
    chk({7'h00, err}, {7'h00, e});
    chk(nwr[7:0], w[7:0]);
  endtask : run
  initial begin
    repeat (20) @(posedge clock_i);
    rst_b_i <= 1'b1;
    run(OP_PROGRAM, 17'h1_0010, 8'h5A, 4, 1'b0);
    chk(u_dev.mem[16], 8'h5A);
    run(OP_PROGRAM, 17'h0_0010, 8'hA5, 5, 1'b1);
    run(OP_RESET, 17'h0_0000, 8'h00, 1, 1'b0);
    run(OP_BYPASS_ENTER, 17'h0_0000, 8'h00, 3, 1'b0);
    chk({7'h00, byp}, 8'h01);
    run(OP_PROGRAM, 17'h0_0020, 8'h33, 2, 1'b0);
    chk(u_dev.mem[32], 8'h33);
    run(OP_CHIP_ERASE, 17'h0_0000, 8'h00, 0, 1'b1);
    run(OP_BYPASS_EXIT, 17'h0_0000, 8'h00, 2, 1'b0);
    chk({7'h00, byp}, 8'h00);
    run(OP_SUSPEND, 17'h0_0000, 8'h00, 0, 1'b1);
    run(OP_SECTOR_ERASE, 17'h0_4000, 8'h00, 6, 1'b0);
    chk({7'h00, win}, 8'h01);
    run(OP_SUSPEND, 17'h1_FFFF, 8'h00, 1, 1'b0);
    run(OP_RESUME, 17'h0_0000, 8'h00, 1, 1'b0);
    run(OP_RESUME, 17'h0_0000, 8'h00, 0, 1'b1);
    n = 0;
    while ((win !== 1'b0 || u_dev.busy > 0) && n < 2000) begin @(posedge clock_i); n++; end
    chk({7'h00, win}, 8'h00);
    run(OP_CHIP_ERASE, 17'h0_0030, 8'h00, 6, 1'b0);
    chk(u_dev.mem[16], 8'hFF);
    complete_run;
  end
  initial begin
    #(100 * 30000);
    mismatches++;
    complete_run;
  end
endmodule : flash_host_ctrl_tb
bind flash_host_ctrl flash_host_chk u_chk (.clock_i(clock_i), .rst_b_i(rst_b_i), .req_i(req_i),
  .flash_addr_o(flash_addr_o), .dq_o(dq_o), .dq_oe_b_o(dq_oe_b_o), .chip_sel_b_o(chip_sel_b_o),
  .write_en_b_o(write_en_b_o), .out_en_b_o(out_en_b_o), .busy_o(busy_o), .done_o(done_o), .error_o(error_o));
